/* File: mid_consts.svh */
// constants for the instruction decoder and sequencer
// assumes: included by the package and the decoder, bare name
`ifndef MID_CONSTS_SVH
`define MID_CONSTS_SVH

// one instruction cycle is four clock periods, phases 0..3
`define MID_OSC_PER_CYC 4
`define MID_Q_FETCH 2'd1
`define MID_Q_DECODE 2'd2
`define MID_Q_LAST 2'(`MID_OSC_PER_CYC - 1)
`define MID_PC_STEP 21'h2

// register byte offsets
`define MID_REG_CTRL 8'h00
`define MID_REG_PC 8'h04
`define MID_REG_IR 8'h08
`define MID_REG_WACC 8'h0c
`define MID_REG_BANK 8'h10
`define MID_REG_TPTR 8'h14
`define MID_REG_PROD 8'h18
`define MID_REG_FLAGS 8'h1c
`define MID_REG_TLAT 8'h20
`define MID_CTRL_RST 1'b1

// opcode fields
`define MID_TAIL_NIB 4'hf
`define MID_MOVFF_NIB 4'hc
`define MID_GOTO_OP 8'hef
`define MID_CALL_OP7 7'h76
`define MID_BRA_OP5 5'h1a
`define MID_RCALL_OP5 5'h1b
`define MID_BCOND_OP5 5'h1c
`define MID_RET_OP15 15'h0009
`define MID_TBL_OP13 13'h0001
`define MID_MULWF_OP7 7'h01
`define MID_MULLW_OP 8'h0d
`define MID_MOVLW_OP 8'h0e
`define MID_MOVLB_OP 8'h01
`define MID_CPF_OP5 5'h0c
`define MID_DECF_OP6 6'h01
`define MID_NEGF_OP7 7'h36
`define MID_FWR_OP5 5'h0d
`define MID_DECFSZ_OP6 6'h0b
`define MID_INCFSZ_OP6 6'h0f
`define MID_NZ_OP5 5'h09
`define MID_ACC_SPLIT 8'h80
`define MID_ACC_HI 4'hf
`define MID_ACC_LO 4'h0

`endif

/* File: mid_pkg.sv */
// types shared by the decoder and its bench
// assumes: mid_consts.svh on the include path
`default_nettype none
`include "mid_consts.svh"

package mid_pkg;
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_WORD2,
    ST_SKIP,
    ST_NOP
  } mid_state_t;

  // table pointer modes: hold, post-inc, post-dec, pre-inc
  typedef logic [1:0] mid_tblmode_t;
  localparam mid_tblmode_t TM_HOLD = 2'h0;
  localparam mid_tblmode_t TM_POSTINC = 2'h1;
  localparam mid_tblmode_t TM_POSTDEC = 2'h2;
  localparam mid_tblmode_t TM_PREINC = 2'h3;
endpackage : mid_pkg

`default_nettype wire

/* File: mid_decoder.sv */
// instruction decoder and sequencer of an 8-bit core, with APB access
// assumes: synchronous program memory (1 clock latency) on pm_addr,
// alu/file/stack outside on the same clock, data valid by phase 3
//
// Operation
// (RQ1) most instructions one word, three take two
// (RQ2) word splits into opcode and operand fields
// (RQ3) second word carries ones in top nibble
// (RQ4) lone second word executes as no-operation
// (RQ5) single word one cycle, taken adds nop
// (RQ6) two-word instructions take two cycles
// (RQ7) instruction cycle equals four clock periods
// (RQ8) true skip over two-word takes three
// (RQ9) d bit picks accumulator or file register
// (RQ10) a bit picks access area or bank
// (RQ11) three-bit field picks bit 0 to 7
// (RQ12) file operand is 8-bit address
// (RQ13) register move carries two 12-bit addresses
// (RQ14) literals decode as 8, 12, 20 bits; code decodes 8, 11 (bra/rcall) and 20
// (RQ15) table pointer hold, post-inc, post-dec, pre-inc
// (RQ16) s bit selects shadow save or restore
// (RQ17) offset relative for branches, direct for calls
// (RQ18) table pointer is 21 bits into program memory
// (RQ19) code fills don't-care bits with zero
// (RQ20) keep carry, digit carry, zero, overflow, negative
// (RQ21) product split into high and low bytes
// (RQ22) opcode from upper bits, operands fixed low
`default_nettype none
`include "mid_consts.svh"

module mid_decoder #(
  parameter int TP_W = 21
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  output logic instr_cycle,
  output mid_pkg::mid_state_t seq_state,
  output logic [7:0] dec_opcode,
  output logic [11:0] file_addr,
  output logic [11:0] move_src_addr,
  output logic [2:0] file_bit,
  output logic [19:0] dec_literal,
  output logic dest_file,
  output logic fast_sel,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] alu_result,
  input wire logic [4:0] alu_flags,
  input wire logic cond_true,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic stack_push,
  output logic stack_pop,
  output logic [20:0] push_addr,
  input wire logic [20:0] stack_top,
  output logic tbl_req,
  output logic tbl_write,
  output logic [TP_W-1:0] tbl_addr,
  output logic [7:0] tbl_wdata,
  input wire logic [7:0] tbl_rdata,
  output logic [7:0] working_accumulator,
  output logic [7:0] product_high_byte,
  output logic [7:0] product_low_byte,
  output logic [4:0] status_flags
);
  import mid_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  logic run_r;
  logic [1:0] phase_r;
  mid_state_t state_r, state_nxt;
  logic [20:0] pc_r, pc_nxt;
  logic adv_r, adv_nxt;
  logic [15:0] ir_r, first_r;
  logic [7:0] wacc_r, bank_r, product_high_byte_r, product_low_byte_r, tlat_r, mvdata_r;
  logic [TP_W-1:0] tptr_r;
  logic [4:0] flags_r;

  ////////////////////////////////////////////////////////////////////
  // phase and field decode
  wire cyc_end = run_r && phase_r == `MID_Q_LAST; // RQ7
  wire fetch_en = run_r && phase_r == `MID_Q_FETCH;
  wire dec_en = run_r && phase_r == `MID_Q_DECODE;
  wire in_exec = state_r == ST_EXEC;
  wire in_word2 = state_r == ST_WORD2;
  wire ex_end = cyc_end && in_exec;

  // RQ22: opcode in the top bits, operands at fixed low positions
  wire [3:0] nib = ir_r[15:12];
  wire [7:0] op8 = ir_r[15:8];
  wire [7:0] k8 = ir_r[7:0]; // RQ14
  wire fld_d = ir_r[9];
  wire fld_a = ir_r[8];
  wire [2:0] fld_b = ir_r[11:9]; // RQ11
  wire is_tail = nib == `MID_TAIL_NIB; // RQ3
  wire is_movff = nib == `MID_MOVFF_NIB;
  wire is_goto = op8 == `MID_GOTO_OP;
  wire is_call = ir_r[15:9] == `MID_CALL_OP7;
  wire is_two = is_movff || is_goto || is_call; // RQ1
  wire is_bra = ir_r[15:11] == `MID_BRA_OP5;
  wire is_rcall = ir_r[15:11] == `MID_RCALL_OP5;
  wire is_bcond = ir_r[15:11] == `MID_BCOND_OP5;
  wire is_ret = ir_r[15:1] == `MID_RET_OP15;
  wire is_tbl = ir_r[15:3] == `MID_TBL_OP13;
  wire tbl_wr_op = ir_r[2];
  wire [1:0] tmode = ir_r[1:0];
  wire is_mulwf = ir_r[15:9] == `MID_MULWF_OP7;
  wire is_mullw = op8 == `MID_MULLW_OP;
  wire is_movlw = op8 == `MID_MOVLW_OP;
  wire is_movlb = op8 == `MID_MOVLB_OP;
  wire is_bitop = nib >= 4'h7 && nib <= 4'hb;
  wire is_bitwr = nib >= 4'h7 && nib <= 4'h9;
  wire is_dop = (nib >= 4'h1 && nib <= 4'h5)
    || ir_r[15:10] == `MID_DECF_OP6;
  wire is_fwr = ir_r[15:11] == `MID_FWR_OP5;
  wire is_negf = ir_r[15:9] == `MID_NEGF_OP7;
  wire is_skip = nib == 4'ha || nib == 4'hb
    || ir_r[15:11] == `MID_CPF_OP5
    || ir_r[15:10] == `MID_DECFSZ_OP6
    || ir_r[15:10] == `MID_INCFSZ_OP6
    || ir_r[15:11] == `MID_NZ_OP5;
  wire first_far = first_r[15:8] == `MID_GOTO_OP
    || first_r[15:9] == `MID_CALL_OP7;
  wire first_call = first_r[15:9] == `MID_CALL_OP7;
  wire first_movff = first_r[15:12] == `MID_MOVFF_NIB;

  // RQ10: access area maps low half to bank 0, high half to the top
  wire [3:0] acc_bank = k8 < `MID_ACC_SPLIT ? `MID_ACC_LO : `MID_ACC_HI;
  wire [11:0] fmapped = fld_a ? {bank_r[3:0], k8} : {acc_bank, k8}; // RQ12
  // RQ13: both move words carry a full 12-bit address in bits 11:0
  wire [11:0] faddr_nxt = (is_movff || in_word2) ? ir_r[11:0] : fmapped;

  // RQ17: relative offsets sign-extend, far targets are direct
  wire [20:0] pc_inc = pc_r + `MID_PC_STEP;
  wire [20:0] rel11 = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
  wire [20:0] rel8 = {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
  wire [20:0] rel_tgt = pc_inc + (is_bcond ? rel8 : rel11);
  wire [20:0] far_tgt = {ir_r[11:0], first_r[7:0], 1'b0}; // RQ14
  wire [19:0] lit_nxt = in_word2 ? {ir_r[11:0], first_r[7:0]}
    : (is_bra || is_rcall) ? {9'h0, ir_r[10:0]} : {12'h0, k8};
  wire taken = is_bra || is_rcall || (is_bcond && cond_true);

  // RQ15: pre-increment moves before the access, posts after
  wire [TP_W-1:0] tp_inc = tptr_r + 1'b1;
  wire [TP_W-1:0] tp_dec = tptr_r - 1'b1;
  wire [TP_W-1:0] tp_use = tmode == TM_PREINC ? tp_inc : tptr_r;
  wire [TP_W-1:0] tp_after = tmode == TM_POSTDEC ? tp_dec
    : tmode == TM_HOLD ? tptr_r : tp_inc;

  wire fwe_nxt = (ex_end && ((is_dop && fld_d) || is_fwr || is_bitwr))
    || (cyc_end && in_word2 && first_movff); // RQ9 RQ13
  wire [7:0] fwd_nxt = in_word2 ? mvdata_r : alu_result;
  wire wacc_ld = ex_end && ((is_dop && !fld_d) || is_movlw); // RQ9
  wire flag_ld = ex_end && (is_dop || is_negf); // RQ20
  wire mul_ld = ex_end && (is_mulwf || is_mullw);
  wire [15:0] product = wacc_r * (is_mullw ? k8 : file_rdata); // RQ21

  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    adv_nxt = 1'b0;
    case (state_r)
      ST_EXEC: begin
        pc_nxt = pc_inc; // RQ5
        if (is_tail) begin
          state_nxt = ST_EXEC; // RQ4
        end else if (is_two) begin
          state_nxt = ST_WORD2; // RQ6
        end else if (taken) begin
          pc_nxt = rel_tgt; // RQ17
          state_nxt = ST_NOP; // RQ5
        end else if (is_ret) begin
          pc_nxt = stack_top;
          state_nxt = ST_NOP; // RQ5
        end else if (is_skip && cond_true) begin
          state_nxt = ST_SKIP; // RQ5
        end
      end
      ST_WORD2: begin
        pc_nxt = first_far ? far_tgt : pc_inc; // RQ6 RQ17
        state_nxt = ST_EXEC;
      end
      ST_SKIP: begin
        pc_nxt = pc_inc;
        adv_nxt = is_two; // RQ8
        state_nxt = is_two ? ST_NOP : ST_EXEC;
      end
      ST_NOP: begin
        pc_nxt = adv_r ? pc_inc : pc_r; // RQ8
        state_nxt = ST_EXEC;
      end
      default: state_nxt = ST_EXEC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
      state_r <= ST_EXEC;
      pc_r <= 21'h0;
      adv_r <= 1'b0;
    end else if (run_r) begin
      phase_r <= phase_r + 2'h1; // RQ7
      if (cyc_end) begin
        state_r <= state_nxt;
        pc_r <= pc_nxt;
        adv_r <= adv_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r <= 16'h0;
      first_r <= 16'h0;
    end else begin
      if (fetch_en) ir_r <= pm_rdata; // RQ2
      if (ex_end) first_r <= ir_r; // RQ1
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoded operand outputs, stable from phase 3 to next phase 3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_opcode <= 8'h0;
      file_addr <= 12'h0;
      move_src_addr <= 12'h0;
      file_bit <= 3'h0;
      dec_literal <= 20'h0;
      dest_file <= 1'b0;
      fast_sel <= 1'b0;
    end else if (dec_en) begin
      dec_opcode <= op8; // RQ22
      file_addr <= faddr_nxt; // RQ10 RQ12 RQ13
      move_src_addr <= in_word2 ? first_r[11:0] : ir_r[11:0]; // RQ13
      file_bit <= is_bitop ? fld_b : 3'h0; // RQ11
      dec_literal <= lit_nxt; // RQ14
      dest_file <= fld_d; // RQ9
      // RQ16: call keeps s in the first word, return in bit 0
      fast_sel <= in_word2 ? first_r[8] : ir_r[0]; // RQ16
    end
  end

  ////////////////////////////////////////////////////////////////////
  // execute strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we <= 1'b0;
      file_wdata <= 8'h0;
      mvdata_r <= 8'h0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      push_addr <= 21'h0;
    end else begin
      file_we <= fwe_nxt;
      if (fwe_nxt) file_wdata <= fwd_nxt;
      if (ex_end && is_movff) mvdata_r <= file_rdata; // RQ13
      stack_push <= (ex_end && is_rcall)
        || (cyc_end && in_word2 && first_call); // RQ17
      stack_pop <= ex_end && is_ret;
      if (ex_end) push_addr <= pc_inc;
      if (cyc_end && in_word2) push_addr <= pc_inc;
    end
  end

  // table access: latch filled one clock after a read request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_req <= 1'b0;
      tbl_write <= 1'b0;
      tbl_addr <= '0;
      tlat_r <= 8'h0;
    end else begin
      tbl_req <= ex_end && is_tbl;
      if (ex_end && is_tbl) begin
        tbl_write <= tbl_wr_op;
        tbl_addr <= tp_use; // RQ15 RQ18
      end
      if (tbl_req && !tbl_write) tlat_r <= tbl_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit = paddr <= `MID_REG_TLAT && paddr[1:0] == 2'h0;
  wire wr_ctrl = apb_wr && paddr == `MID_REG_CTRL;
  wire wr_wacc = apb_wr && paddr == `MID_REG_WACC;
  wire wr_bank = apb_wr && paddr == `MID_REG_BANK;
  wire wr_tptr = apb_wr && paddr == `MID_REG_TPTR;
  wire wr_flags = apb_wr && paddr == `MID_REG_FLAGS;
  logic [31:0] rd_mux;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    case (paddr)
      `MID_REG_CTRL: rd_mux = {31'h0, run_r};
      `MID_REG_PC: rd_mux = {11'h0, pc_r};
      `MID_REG_IR: rd_mux = {first_r, ir_r};
      `MID_REG_WACC: rd_mux = {24'h0, wacc_r};
      `MID_REG_BANK: rd_mux = {24'h0, bank_r};
      `MID_REG_TPTR: rd_mux = 32'(tptr_r);
      `MID_REG_PROD: rd_mux = {16'h0, product_high_byte_r, product_low_byte_r};
      `MID_REG_FLAGS: rd_mux = {27'h0, flags_r};
      `MID_REG_TLAT: rd_mux = {24'h0, tlat_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (apb_setup) prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////
  // architectural registers; the core wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= `MID_CTRL_RST;
      wacc_r <= 8'h0;
      bank_r <= 8'h0;
      tptr_r <= '0;
      flags_r <= 5'h0;
      product_high_byte_r <= 8'h0;
      product_low_byte_r <= 8'h0;
    end else begin
      if (wr_ctrl) run_r <= pwdata[0];
      if (wacc_ld) wacc_r <= is_movlw ? k8 : alu_result; // RQ9
      else if (wr_wacc) wacc_r <= pwdata[7:0];
      if (ex_end && is_movlb) bank_r <= {4'h0, ir_r[3:0]}; // RQ10
      else if (wr_bank) bank_r <= pwdata[7:0];
      if (ex_end && is_tbl) tptr_r <= tp_after; // RQ15
      else if (wr_tptr) tptr_r <= pwdata[TP_W-1:0];
      if (flag_ld) flags_r <= alu_flags; // RQ20
      else if (wr_flags) flags_r <= pwdata[4:0];
      if (mul_ld) begin
        product_high_byte_r <= product[15:8]; // RQ21
        product_low_byte_r <= product[7:0];
      end
    end
  end

  assign pm_addr = pc_r;
  assign instr_cycle = cyc_end;
  assign seq_state = state_r;
  assign tbl_wdata = tlat_r;
  assign working_accumulator = wacc_r;
  assign product_high_byte = product_high_byte_r;
  assign product_low_byte = product_low_byte_r;
  assign status_flags = flags_r;

endmodule : mid_decoder

`default_nettype wire

/* File: mid_decoder_props.sv */
// concurrent checks on sequencing, effect pulses and the bus answer
// assumes: bound into every mid_decoder, single clock domain
`default_nettype none
module mid_decoder_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [20:0] pm_addr,
  input wire logic instr_cycle,
  input wire mid_pkg::mid_state_t seq_state,
  input wire logic [7:0] dec_opcode,
  input wire logic [2:0] file_bit,
  input wire logic file_we,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic tbl_req
);
  import mid_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////
  a_cycle_period: assert property (
    instr_cycle |=> !instr_cycle [*3] ##1 instr_cycle)
    else $error("instruction cycle length wrong");
  a_pc_boundary: assert property (
    $changed(pm_addr) |-> $past(instr_cycle))
    else $error("program address moved inside a cycle");
  a_state_boundary: assert property (
    $changed(seq_state) |-> $past(instr_cycle))
    else $error("sequencer state moved inside a cycle");
  a_word2_once: assert property (
    instr_cycle && seq_state == ST_WORD2 |=> seq_state != ST_WORD2)
    else $error("second word held longer than one cycle");
  a_word2_kind: assert property (
    $rose(seq_state == ST_WORD2) |->
      dec_opcode[7:4] == 4'hc || dec_opcode[7:4] == 4'he)
    else $error("second word after a one-word opcode");
  a_nop_quiet: assert property (
    instr_cycle && seq_state == ST_NOP |=>
      !file_we && !stack_push && !stack_pop && !tbl_req)
    else $error("no-operation cycle had an effect");
  a_effect_phase: assert property (
    file_we || tbl_req || stack_push || stack_pop |-> $past(instr_cycle))
    else $error("effect pulse outside phase 0");
  a_bit_field: assert property (
    file_bit != 3'h0 |->
      dec_opcode[7:4] inside {4'h7, 4'h8, 4'h9, 4'ha, 4'hb})
    else $error("bit number set for a non-bit opcode");
  a_skip_bound: assert property (
    $rose(seq_state == ST_SKIP) |-> ##[4:8] seq_state != ST_SKIP)
    else $error("skip lasted over two cycles");
  a_push_pulse: assert property (
    stack_push |=> !stack_push)
    else $error("stack push longer than one clock");
  a_ready_high: assert property (
    psel && penable |-> pready)
    else $error("access phase without ready");
  a_unmapped_err: assert property (
    psel && penable && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access without error");
endmodule : mid_decoder_props

bind mid_decoder mid_decoder_props u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .pm_addr, .instr_cycle, .seq_state, .dec_opcode,
  .file_bit, .file_we, .stack_push, .stack_pop, .tbl_req);
`default_nettype wire

/* File: mid_pmem_model.sv */
// program memory answering the core's fetch port
// assumes: words loaded by the bench before reset is released
`default_nettype none
module mid_pmem_model (
  input wire logic pclk,
  input wire logic [20:0] pm_addr,
  output logic [15:0] pm_rdata
);
  logic [15:0] mem [256];
  ////////////////////////////////////////////////////////////////////
  // one clock read latency; small array, upper address bits wrap
  always_ff @(posedge pclk) begin
    pm_rdata <= mem[pm_addr[8:1]];
  end
endmodule : mid_pmem_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the instruction decoder and sequencer
// assumes: program memory model and checker compiled before it
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mid_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic cond_true = 0, ctl = 0, pready, pslverr, instr_cycle, dest_file;
  logic fast_sel, file_we, stack_push, stack_pop, tbl_req, tbl_write;
  logic [7:0] paddr = '0, file_rdata = '0, alu_result = '0, tbl_rdata = '0;
  logic [7:0] dec_opcode, file_wdata, tbl_wdata, working_accumulator;
  logic [7:0] product_high_byte, product_low_byte;
  logic [31:0] pwdata = '0, prdata, lfsr = 32'h111f9, rs = 32'h111f9;
  logic [4:0] alu_flags = '0, status_flags;
  logic [20:0] pm_addr, push_addr, stack_top = '0, tbl_addr, tq [$];
  logic [15:0] pm_rdata;
  logic [11:0] file_addr, move_src_addr;
  logic [2:0] file_bit;
  logic [19:0] dec_literal;
  mid_state_t seq_state;
  int mismatches = 0, n_checks = 0, np = 0, npop = 0, nt = 0, nf = 0;
  mid_decoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pm_addr, .pm_rdata, .instr_cycle, .seq_state,
    .dec_opcode, .file_addr, .move_src_addr, .file_bit, .dec_literal,
    .dest_file, .fast_sel, .file_rdata, .alu_result, .alu_flags, .cond_true,
    .file_we, .file_wdata, .stack_push, .stack_pop, .push_addr, .stack_top,
    .tbl_req, .tbl_write, .tbl_addr, .tbl_wdata, .tbl_rdata,
    .working_accumulator, .product_high_byte, .product_low_byte,
    .status_flags);
  mid_pmem_model pm (.pclk, .pm_addr, .pm_rdata);
  //////////////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : nxt
  function automatic logic [11:0] fa(input logic a, input logic [7:0] f,
                                     input logic [3:0] bk);
    if (a)
      return {bk, f};
    return f < 8'h80 ? {4'h0, f} : {4'hf, f};
  endfunction : fa
  always @(posedge pclk) begin
    lfsr <= nxt(lfsr);
    alu_result <= lfsr[7:0];
    alu_flags <= lfsr[12:8];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // waits for the ready edge however long the slave takes
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  task automatic next_cyc();
    int t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (instr_cycle !== 1'b1 && t < 20);
    if (instr_cycle !== 1'b1) mismatches++;
  endtask : next_cyc
  // effect pulses of the flow program, counted as they occur
  always @(negedge pclk) begin
    if (presetn && ctl) begin
      if (stack_push) chk(push_addr, 21'h4);
      if (tbl_req) chk(tbl_addr, tq.pop_front());
      if (tbl_req) chk(tbl_write, nt == 2);
      if (tbl_req && tbl_write) chk(tbl_wdata, 8'h3c);
      if (file_we) chk(file_wdata, 8'h5a);
      np += stack_push;
      npop += stack_pop;
      nt += tbl_req;
      nf += file_we;
    end
  end
  initial begin
    #250000;
    mismatches++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] w;
    logic [7:0] r;
    logic [4:0] fl;
    logic [3:0] bk;
    logic [7:0] acc;
    logic [7:0] ra [7] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [7:0] wa [4] = '{8'h0c, 8'h1c, 8'h14, 8'h18};
    logic [31:0] wm [4] = '{32'hff, 32'h1f, 32'h1fffff, 32'h0};
    logic [7:0] ci [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21, 8'h22,
      8'h23, 8'h28, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
    logic [15:0] cw [16] = '{16'hed20, 16'hf000, 16'hef40, 16'hf000,
      16'h2c10, 16'hc0ab, 16'hf0cd, 16'hd004, 16'h0012, 16'hf123, 16'hc0ab,
      16'hf0cd, 16'h0009, 16'h000b, 16'h000e, 16'h0008};
    logic [8:0] tr [20] = '{9'h1ed, 9'h0, 9'h12c, 9'h0, 9'h0, 9'h1d0, 9'h0,
      9'h100, 9'h0, 9'h1ef, 9'h0, 9'h0f1, 9'h1c0, 9'h0, 9'h100, 9'h100,
      9'h100, 9'h100, 9'h1d7, 9'h0};
    // lone second words only, so the core idles while registers are probed
    for (int i = 0; i < 256; i++) pm.mem[i] = 16'hf000;
    rst();
    foreach (ra[i]) begin
      apb(1'b0, ra[i], '0, q, e);
      chk(q, {31'h0, i == 0});
      chk(e, 1'b0);
    end
    apb(1'b0, 8'h24, '0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 8'h02, '0, q, e);
    chk(e, 1'b1);
    foreach (wa[i]) begin
      rs = nxt(rs);
      apb(1'b1, wa[i], rs, q, e);
      apb(1'b0, wa[i], '0, q, e);
      chk(q, rs & wm[i]);
    end
    $display("test registers done");
    for (int i = 2; i < 26; i++) begin
      rs = nxt(rs);
      case (rs[17:16])
        2'h0: pm.mem[i] = {6'b001001, rs[9:0]};
        2'h1: pm.mem[i] = {4'h8, rs[11:0]};
        2'h2: pm.mem[i] = {8'h0d, rs[7:0]};
        default: pm.mem[i] = {8'h0e, rs[7:0]};
      endcase
    end
    pm.mem[26] = 16'hd7ff;
    bk = rs[23:20];
    rst();
    apb(1'b1, 8'h10, {28'h0, bk}, q, e);
    acc = 8'h0;
    for (int k = 0; k < 26; k++) begin
      next_cyc();
      w = pm.mem[k];
      r = alu_result;
      fl = alu_flags;
      chk(pm_addr, 21'(2 * k));
      chk(dec_opcode, w[15:8]);
      chk(file_bit, w[15:12] == 4'h8 ? w[11:9] : 3'h0);
      if (w[15:12] == 4'h8 || w[15:10] == 6'b001001)
        chk(file_addr, fa(w[8], w[7:0], bk));
      if (w[15:10] == 6'b001001) chk(dest_file, w[9]);
      if (w[15:8] == 8'h0e) chk(dec_literal[7:0], w[7:0]);
      @(negedge pclk);
      if (w[15:10] == 6'b001001) begin
        chk(file_we, w[9]);
        if (w[9]) chk(file_wdata, r);
        else chk(working_accumulator, r);
        chk(status_flags, fl);
        if (!w[9]) acc = r;
      end
      if (w[15:8] == 8'h0d)
        chk({product_high_byte, product_low_byte}, acc * w[7:0]);
      if (w[15:8] == 8'h0e) begin
        chk(working_accumulator, w[7:0]);
        acc = w[7:0];
      end
    end
    $display("test random decode done");
    foreach (ci[i]) pm.mem[ci[i]] = cw[i];
    pm.mem[8'h47] = 16'hd7ff;
    @(posedge pclk);
    cond_true <= 1'b1;
    file_rdata <= 8'h5a;
    tbl_rdata <= 8'h3c;
    stack_top <= 21'h4;
    tq = '{21'h100, 21'h102, 21'h102, 21'h101};
    rst();
    ctl = 1'b1;
    apb(1'b1, 8'h14, 32'h100, q, e);
    for (int k = 0; k < 20; k++) begin
      next_cyc();
      if (tr[k][8]) chk({seq_state === ST_EXEC, dec_opcode}, tr[k]);
      else if (tr[k] == 9'h0) chk(seq_state !== ST_EXEC, 1'b1);
      else chk(dec_opcode, tr[k][7:0]);
      if (k == 1) chk(fast_sel, 1'b1);
      if (k == 7) chk(fast_sel, 1'b0);
      if (k == 5) chk(dec_literal, 20'h4);
      if (k == 10) chk(dec_literal, 20'h40);
      if (k == 13) chk({move_src_addr, file_addr}, 24'h0ab0cd);
    end
    ctl = 1'b0;
    chk({8'(np), 8'(npop), 8'(nt), 8'(nf)}, 32'h01010401);
    apb(1'b0, 8'h14, '0, q, e);
    chk(q, 32'h101);
    apb(1'b0, 8'h20, '0, q, e);
    chk(q, 32'h3c);
    $display("test program flow done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
